// ---- hw/e1_shaper_defines.svh ----
// Purpose: Named offsets, fields, resets and counts of the E1 transmit shaper
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef E1_SHAPER_DEFINES_SVH
`define E1_SHAPER_DEFINES_SVH

// Register offsets
`define OFF_TERM 8'h03
`define OFF_SHAPE 8'h06
`define OFF_TRIM 8'h07
`define OFF_ACC 8'h08
`define OFF_SAMPLE 8'h09
`define OFF_MASK 8'h15
`define OFF_STAT 8'h1a

// Field positions
`define TERM_EXT 2
`define TERM_120 0
`define SHAPE_ARB_HI 3
`define SHAPE_ARB_LO 2
`define SHAPE_120 0
`define SHAPE_TRI 4
`define ACC_STROBE 7
`define ACC_DIR 6
`define BIT_OVF 0
`define BIT_TX_CLOCK_IN 1

// Reset values
`define TRIM_RESET 6'h21
`define TERM_RESET 8'h00
`define SHAPE_RESET 8'h00

// Preset template samples
`define PRE_EDGE_SUB 4'h3
`define PRE_FLAT_FIRST 4'h4
`define PRE_FLAT_LAST 4'hb
`define PRE75_EDGE 6'h0c
`define PRE75_FLAT 6'h30
`define PRE120_EDGE 6'h0f
`define PRE120_FLAT 6'h3c

// Amplitude limits and scaling
`define MAG_MAX 6'h3f
`define SCALE_SHIFT 6
`define SCALE_OFS 8'h02

// Timing
`define MCLK_PS 10000
`define SUBPHASE_PS 30518
`define SUBPHASE_CYC (`SUBPHASE_PS / `MCLK_PS)
`define TX_CLOCK_IN_LOSS_CYC 70

`endif

// ---- hw/e1_shaper_pkg.sv ----
// Purpose: State types of the E1 transmit shaper
// Assumes: Nothing
// Notes: Constants live in the defines header
package e1_shaper_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_XFER = 3'b010,
        ST_LOAD = 3'b100
    } access_state_e;

    typedef struct packed {
        logic [2:0] sync;
        logic level;
        logic [6:0] gap;
        logic lost;
    } monitor_s;

    typedef struct packed {
        logic [6:0] s1;
        logic [6:0] s2;
        logic [6:0] s3;
        logic [6:0] flt;
        logic [7:0] term;
        logic [4:0] shape;
        logic [5:0] trim;
        logic [7:0] acc;
        logic [6:0] sample;
        logic [1:0] mask;
        logic [1:0] stat;
        logic [7:0] rdata;
        access_state_e st;
        logic [1:0] div;
        logic [3:0] phase;
        logic [3:0] hist_mark;
        logic [3:0] hist_neg;
        logic [6:0] dac;
        logic drv_en;
        logic lost_d;
    } shaper_s;

endpackage

// ---- hw/tx_clock_monitor.sv ----
// Purpose: Detect a missing transmit clock on the master clock
// Assumes: Transmit clock arrives on a pin, asynchronous
// Notes: Three-stage sync, change counts when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
`include "e1_shaper_defines.svh"

module tx_clock_monitor (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Pin
    input wire logic i_tx_clock_in,
    // Status
    output logic o_lost
);
    e1_shaper_pkg::monitor_s s;
    e1_shaper_pkg::monitor_s nx;

    always_comb begin
        nx = s;
        nx.sync = {s.sync[1:0], i_tx_clock_in};
        if (s.sync[1] == s.sync[2] && s.sync[2] != s.level) begin
            nx.level = s.sync[2];
            nx.gap = 7'h00;
            nx.lost = 1'b0;
        end else if (s.gap != 7'(`TX_CLOCK_IN_LOSS_CYC)) begin
            nx.gap = s.gap + 7'h01;
        end else begin
            nx.lost = 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            s <= '0;
        end else begin
            s <= nx;
        end
    end

    assign o_lost = s.lost;

    a_loss_after_gap: assert property (@(posedge i_mclk) disable iff (i_rst)
        $rose(s.lost) |-> $past(s.gap) == 7'(`TX_CLOCK_IN_LOSS_CYC))
        else $error("clock loss flagged at wrong gap");
endmodule
`default_nettype wire

// ---- hw/waveform_ram.sv ----
// Purpose: 64-entry sample store for the arbitrary waveform
// Assumes: One host port, four combinational shaper read ports
// Notes: Host read data is registered
`timescale 1ns/1ps
`default_nettype none

module waveform_ram (
    // Clock
    input wire logic i_mclk,
    // Host port
    input wire logic [5:0] i_addr,
    input wire logic i_wr,
    input wire logic [6:0] i_wdata,
    output logic [6:0] o_rdata,
    // Shaper ports, one per interval
    input wire logic [23:0] i_ra,
    output logic [27:0] o_rd
);
    logic [6:0] mem [64];

    always_ff @(posedge i_mclk) begin
        if (i_wr) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end

    for (genvar k = 0; k < 4; k++) begin : g_port
        assign o_rd[k*7 +: 7] = mem[i_ra[k*6 +: 6]];
    end
endmodule
`default_nettype wire

// ---- hw/e1_tx_pulse_shaper_ctrl.sv ----
// Purpose: E1 transmit pulse shape, termination and driver control
// Assumes: Registers at their printed offsets, straps on pins
// Notes: Symbol strobe marks each unit interval start
`timescale 1ns/1ps
`default_nettype none
`include "e1_shaper_defines.svh"

module e1_tx_pulse_shaper_ctrl (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Register port
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // Hardware control straps
    input wire logic i_hw_mode,
    input wire logic i_strap_tristate,
    input wire logic i_strap_term,
    input wire logic [3:0] i_strap_shape,
    // Transmit path state
    input wire logic i_tx_clock_in,
    input wire logic i_mclk_fail,
    input wire logic i_tx_power_down,
    input wire logic i_remote_loop,
    input wire logic i_mclk_pattern,
    // Symbols from the encoder
    input wire logic i_sym_valid,
    input wire logic i_sym_mark,
    input wire logic i_sym_neg,
    // Line driver
    output logic [6:0] o_dac_code,
    output logic o_line_out_pos_oe,
    output logic o_line_out_neg_oe,
    output logic o_term_internal,
    output logic o_term_120,
    output logic o_irq
);
    e1_shaper_pkg::shaper_s s;
    e1_shaper_pkg::shaper_s nx;

    logic tx_clock_in_lost;
    logic [6:0] ram_rdata;
    logic [23:0] ram_ra;
    logic [27:0] ram_rd;
    logic ram_wr;
    logic tick;
    logic hw_tri;
    logic hw_term;
    logic [3:0] hw_shape;
    logic mclk_fail;
    logic tri_eff;
    logic int_eff;
    logic sel120_eff;
    logic tpl120;
    logic arb_mode;
    logic [5:0] trim_eff;
    logic [7:0] factor;
    logic signed [8:0] contrib [4];
    logic signed [9:0] sum;
    logic signed [17:0] prod;
    logic signed [17:0] scaled;
    logic ovf;
    logic [5:0] pre_mag;
    logic [6:0] code;

    tx_clock_monitor u_mon (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_tx_clock_in(i_tx_clock_in),
        .o_lost(tx_clock_in_lost)
    );

    waveform_ram u_ram (
        .i_mclk(i_mclk),
        .i_addr(s.acc[5:0]),
        .i_wr(ram_wr),
        .i_wdata(s.sample),
        .o_rdata(ram_rdata),
        .i_ra(ram_ra),
        .o_rd(ram_rd)
    );

    // Filtered straps
    assign mclk_fail = s.flt[6];
    assign hw_tri = s.flt[5];
    assign hw_term = s.flt[4];
    assign hw_shape = s.flt[3:0];

    // Effective controls
    assign tri_eff = i_hw_mode ? hw_tri : s.shape[`SHAPE_TRI];
    assign int_eff = i_hw_mode ? hw_term : !s.term[`TERM_EXT];
    assign sel120_eff = i_hw_mode ? hw_shape[`SHAPE_120]
                                  : s.term[`TERM_120];
    assign arb_mode = i_hw_mode ? (hw_shape[3] & hw_shape[2])
                                : (s.shape[`SHAPE_ARB_HI] & s.shape[`SHAPE_ARB_LO]);
    assign trim_eff = i_hw_mode ? `TRIM_RESET : s.trim;
    // Preset choice follows the template select, not the termination
    assign tpl120 = i_hw_mode ? hw_shape[`SHAPE_120]
                              : (s.shape[`SHAPE_ARB_HI:`SHAPE_120] != 4'h0);

    // Host RAM access
    assign ram_wr = (s.st == e1_shaper_pkg::ST_XFER) && !s.acc[`ACC_DIR];
    assign tick = (s.div == 2'(`SUBPHASE_CYC - 1));

    // Contribution of the pulse begun k intervals ago
    for (genvar k = 0; k < 4; k++) begin : g_ui
        logic [6:0] smp;
        logic signed [8:0] val;
        assign ram_ra[k*6 +: 6] = {2'(k), s.phase};
        assign smp = ram_rd[k*7 +: 7];
        assign val = smp[6] ? -$signed({3'h0, smp[5:0]})
                            : $signed({3'h0, smp[5:0]});
        assign contrib[k] = !s.hist_mark[k] ? 9'sh000
                          : (s.hist_neg[k] ? -val : val);
    end

    // About 3% per trim step, 33 gives unity
    assign factor = (trim_eff == 6'h00) ? 8'h00
                  : ({1'b0, trim_eff, 1'b0} - `SCALE_OFS);
    assign sum = 10'(contrib[0]) + 10'(contrib[1])
               + 10'(contrib[2]) + 10'(contrib[3]);
    assign prod = 18'(sum) * 18'($signed({1'b0, factor}));
    assign scaled = prod >>> `SCALE_SHIFT;
    assign ovf = (scaled > 18'sd63) || (scaled < -18'sd63);

    // Preset ROM, first interval only, never scaled
    always_comb begin
        pre_mag = 6'h00;
        if (s.phase == `PRE_EDGE_SUB) begin
            pre_mag = tpl120 ? `PRE120_EDGE : `PRE75_EDGE;
        end else if (s.phase >= `PRE_FLAT_FIRST && s.phase <= `PRE_FLAT_LAST) begin
            pre_mag = tpl120 ? `PRE120_FLAT : `PRE75_FLAT;
        end
    end

    always_comb begin
        code = 7'h00;
        if (arb_mode) begin
            if (ovf) begin
                code = {scaled[17], `MAG_MAX};
            end else if (scaled[17]) begin
                code = {1'b1, 6'(-scaled)};
            end else begin
                code = {1'b0, scaled[5:0]};
            end
        end else if (s.hist_mark[0]) begin
            code = {s.hist_neg[0] && pre_mag != 6'h00, pre_mag};
        end
    end

    always_comb begin
        nx = s;
        // Three-stage strap synchroniser
        nx.s1 = {i_mclk_fail, i_strap_tristate, i_strap_term, i_strap_shape};
        nx.s2 = s.s1;
        nx.s3 = s.s2;
        nx.flt = ((s.s2 ~^ s.s3) & s.s3) | ((s.s2 ^ s.s3) & s.flt);
        // Register writes
        if (i_reg_wr) begin
            case (i_reg_addr)
                `OFF_TERM: nx.term = i_reg_wdata;
                `OFF_SHAPE: nx.shape = i_reg_wdata[4:0];
                `OFF_TRIM: nx.trim = i_reg_wdata[5:0];
                `OFF_ACC: begin
                    if (s.st == e1_shaper_pkg::ST_IDLE && !s.acc[`ACC_STROBE]) begin
                        nx.acc = i_reg_wdata;
                    end
                end
                `OFF_SAMPLE: nx.sample = i_reg_wdata[6:0];
                `OFF_MASK: nx.mask = i_reg_wdata[1:0];
                default: nx.rdata = s.rdata;
            endcase
        end
        // Register reads
        if (i_reg_rd) begin
            case (i_reg_addr)
                `OFF_TERM: nx.rdata = s.term;
                `OFF_SHAPE: nx.rdata = {3'h0, s.shape};
                `OFF_TRIM: nx.rdata = {2'h0, s.trim};
                `OFF_ACC: nx.rdata = s.acc;
                `OFF_SAMPLE: nx.rdata = {1'b0, s.sample};
                `OFF_MASK: nx.rdata = {6'h00, s.mask};
                `OFF_STAT: nx.rdata = {6'h00, s.stat};
                default: nx.rdata = 8'h00;
            endcase
        end
        // Access sequencer
        case (s.st)
            e1_shaper_pkg::ST_IDLE: begin
                if (s.acc[`ACC_STROBE]) begin
                    nx.st = e1_shaper_pkg::ST_XFER;
                end
            end
            e1_shaper_pkg::ST_XFER: begin
                if (s.acc[`ACC_DIR]) begin
                    nx.st = e1_shaper_pkg::ST_LOAD;
                end else begin
                    nx.st = e1_shaper_pkg::ST_IDLE;
                    nx.acc[`ACC_STROBE] = 1'b0;
                end
            end
            e1_shaper_pkg::ST_LOAD: begin
                nx.sample = ram_rdata;
                nx.acc[`ACC_STROBE] = 1'b0;
                nx.st = e1_shaper_pkg::ST_IDLE;
            end
            default: nx.st = e1_shaper_pkg::ST_IDLE;
        endcase
        // Sub-phase timing and symbol history
        if (i_sym_valid) begin
            nx.hist_mark = {s.hist_mark[2:0], i_sym_mark};
            nx.hist_neg = {s.hist_neg[2:0], i_sym_neg};
            nx.phase = 4'h0;
            nx.div = 2'h0;
        end else if (tick) begin
            nx.div = 2'h0;
            if (s.phase != 4'hf) begin
                nx.phase = s.phase + 4'h1;
            end
        end else begin
            nx.div = s.div + 2'h1;
        end
        nx.dac = code;
        // Line driver enable
        nx.drv_en = !(tri_eff || i_tx_power_down || mclk_fail
                      || (tx_clock_in_lost && !(i_remote_loop || i_mclk_pattern)));
        // Sticky status, set wins over clear on read
        nx.lost_d = tx_clock_in_lost;
        if (i_reg_rd && i_reg_addr == `OFF_STAT) begin
            nx.stat = 2'h0;
        end
        if (arb_mode && ovf) begin
            nx.stat[`BIT_OVF] = 1'b1;
        end
        if (tx_clock_in_lost && !s.lost_d) begin
            nx.stat[`BIT_TX_CLOCK_IN] = 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            s <= '0;
            s.term <= `TERM_RESET;
            s.shape <= 5'(`SHAPE_RESET);
            s.trim <= `TRIM_RESET;
            s.st <= e1_shaper_pkg::ST_IDLE;
            s.drv_en <= 1'b0;
        end else begin
            s <= nx;
        end
    end

    assign o_reg_rdata = s.rdata;
    assign o_dac_code = s.dac;
    assign o_line_out_pos_oe = s.drv_en;
    assign o_line_out_neg_oe = s.drv_en;
    assign o_term_internal = int_eff;
    assign o_term_120 = sel120_eff;
    assign o_irq = |(s.stat & s.mask);

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    a_tristate_bit_hiz: assert property (
        (!i_hw_mode && s.shape[`SHAPE_TRI]) |=> !o_line_out_pos_oe && !o_line_out_neg_oe)
        else $error("driver active with tristate bit set");
    a_strap_tri_hiz: assert property (
        (i_hw_mode && hw_tri) |=> !o_line_out_pos_oe)
        else $error("driver active with tristate strap high");
    a_power_down_hiz: assert property (
        i_tx_power_down |=> !o_line_out_pos_oe && !o_line_out_neg_oe)
        else $error("driver active in power down");
    a_clock_loss_hiz: assert property (
        (tx_clock_in_lost && !i_remote_loop && !i_mclk_pattern) |=> !o_line_out_neg_oe)
        else $error("driver active with transmit clock lost");
    a_reset_release_hiz: assert property (
        $fell(i_rst) |-> !o_line_out_pos_oe && s.trim == `TRIM_RESET)
        else $error("state wrong after reset release");
    a_overflow_sticky: assert property (
        (arb_mode && ovf) |=> s.stat[`BIT_OVF]
        ##1 (s.stat[`BIT_OVF] || $past(i_reg_rd && i_reg_addr == `OFF_STAT)))
        else $error("overflow not held in status");
    a_irq_masked: assert property (
        (s.stat[`BIT_OVF] && !s.mask[`BIT_OVF] && !s.stat[`BIT_TX_CLOCK_IN]) |-> !o_irq)
        else $error("interrupt raised while masked");
    a_access_done: assert property (
        (s.st == e1_shaper_pkg::ST_IDLE && s.acc[`ACC_STROBE])
        |=> ##[1:2] !s.acc[`ACC_STROBE])
        else $error("access strobe not cleared");
    a_preset_unscaled: assert property (
        (!arb_mode && s.hist_mark[0] && s.phase == `PRE_FLAT_FIRST)
        |=> o_dac_code[5:0] == (tpl120 ? 6'(`PRE120_FLAT) : 6'(`PRE75_FLAT)))
        else $error("preset sample altered");
    a_read_back: assert property (
        (s.st == e1_shaper_pkg::ST_LOAD) |=> s.sample == $past(ram_rdata))
        else $error("read-back sample not loaded");
    a_mclk_loss_hiz: assert property (
        mclk_fail |=> !o_line_out_pos_oe && !o_line_out_neg_oe)
        else $error("driver active with master clock lost");
    a_tx_clock_in_loss_flag: assert property (
        $rose(tx_clock_in_lost) |=> s.stat[`BIT_TX_CLOCK_IN])
        else $error("transmit clock loss not flagged");
    a_tx_clock_in_irq: assert property (
        (s.stat[`BIT_TX_CLOCK_IN] && s.mask[`BIT_TX_CLOCK_IN]) |-> o_irq)
        else $error("clock loss interrupt missing");
    a_arb_saturate: assert property (
        (arb_mode && ovf) |=> o_dac_code[5:0] == `MAG_MAX)
        else $error("overflowed sample not saturated");
    a_space_silent: assert property (
        (!arb_mode && !s.hist_mark[0]) |=> o_dac_code == 7'h00)
        else $error("preset space not silent");
    a_strobe_busy: assert property (
        (s.st != e1_shaper_pkg::ST_IDLE) |-> s.acc[`ACC_STROBE])
        else $error("access running without strobe");
    a_busy_write_ignored: assert property (
        (i_reg_wr && i_reg_addr == `OFF_ACC && s.acc[`ACC_STROBE])
        |=> s.acc[5:0] == $past(s.acc[5:0]))
        else $error("access address changed while busy");
    a_phase_hold: assert property (
        (s.phase == 4'hf && !i_sym_valid) |=> s.phase == 4'hf)
        else $error("sub-phase ran past the last");
    a_reset_dac_zero: assert property (
        $fell(i_rst) |-> o_dac_code == 7'h00 && !o_irq)
        else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

// ---- verification/e1_line_model.sv ----
// Purpose: Line driver and cable as seen from the shaper
// Assumes: Transmit clock pin is made here at 2.048 MHz
// Notes: A floated line shows the inverse of its last level
`timescale 1ns/1ps
`default_nettype none

module e1_line_model (
    // Control
    input wire logic i_run,
    // Driver side
    input wire logic [6:0] i_dac_code,
    input wire logic i_pos_oe,
    input wire logic i_neg_oe,
    // Line and clock
    output logic o_tx_clock,
    output logic o_driven,
    output logic [6:0] o_level
);
    logic [6:0] last = 7'h00;
    initial o_tx_clock = 1'b0;
    // Clock stands still while stopped
    always #244 if (i_run) o_tx_clock = ~o_tx_clock;
    assign o_driven = i_pos_oe & i_neg_oe;
    always @(i_dac_code or o_driven) if (o_driven) last = i_dac_code;
    assign o_level = o_driven ? i_dac_code : ~last;
endmodule
`default_nettype wire

// ---- verification/e1_tx_pulse_shaper_ctrl_tb.sv ----
// Purpose: Register, shaping and driver checks of the transmit shaper
// Assumes: Line model makes the transmit clock
// Notes: Tasks start and end just after a clock edge
`timescale 1ns/1ps
`default_nettype none
`include "e1_shaper_defines.svh"

module e1_tx_pulse_shaper_ctrl_tb;
    logic clk, rst, wr, rd, hw, s_tri, s_term, mfail, pd, rloop, mpat, sv, sm, sn, run;
    logic [7:0] addr, wdata, rdata, rv;
    logic [3:0] s_shape;
    logic [6:0] dac, lvl;
    logic tx_clock_in, poe, noe, tint, t120, irq, drv;
    int fail_count = 0;
    int checks = 0;

    e1_tx_pulse_shaper_ctrl DUT (
        .i_mclk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_hw_mode(hw), .i_strap_tristate(s_tri),
        .i_strap_term(s_term), .i_strap_shape(s_shape), .i_tx_clock_in(tx_clock_in),
        .i_mclk_fail(mfail), .i_tx_power_down(pd), .i_remote_loop(rloop),
        .i_mclk_pattern(mpat), .i_sym_valid(sv), .i_sym_mark(sm), .i_sym_neg(sn),
        .o_dac_code(dac), .o_line_out_pos_oe(poe), .o_line_out_neg_oe(noe),
        .o_term_internal(tint), .o_term_120(t120), .o_irq(irq)
    );

    e1_line_model line (
        .i_run(run), .i_dac_code(dac), .i_pos_oe(poe), .i_neg_oe(noe),
        .o_tx_clock(tx_clock_in), .o_driven(drv), .o_level(lvl)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        step(1);
        addr = a;
        wdata = d;
        wr = 1'b1;
        step(1);
        wr = 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a);
        step(1);
        addr = a;
        rd = 1'b1;
        step(1);
        rd = 1'b0;
        step(1);
        rv = rdata;
    endtask

    task automatic ram(input logic [1:0] u, input logic [3:0] s, input logic dir,
                       input logic [7:0] d);
        int n;
        n = 0;
        if (!dir) wreg(`OFF_SAMPLE, d);
        wreg(`OFF_ACC, {1'b1, dir, u, s});
        if (dir) wreg(`OFF_ACC, {2'b10, ~u, s});
        rv = 8'h80;
        while (rv[7] && n < 20) begin
            rreg(`OFF_ACC);
            n++;
        end
        check({7'h0, rv[7]}, 8'h00);
        if (dir) rreg(`OFF_SAMPLE);
    endtask

    task automatic oe(input logic exp);
        step(8);
        check({6'h0, poe, noe}, {6'h0, exp, exp});
        check({7'h0, drv}, {7'h0, exp});
    endtask

    function automatic logic [7:0] tbl(input int u, input int s);
        return (u == 0) ? 8'(s * 4) : (u == 1) ? 8'h28 : 8'h00;
    endfunction

    function automatic logic [6:0] wave(input int mode, input int p, input int trim);
        int v;
        case (mode)
            0: v = (p == 3) ? 12 : (p >= 4 && p <= 11) ? 48 : 0;
            1: v = (p == 3) ? 15 : (p >= 4 && p <= 11) ? 60 : 0;
            2: v = p * 4 * (2 * trim - 2) / 64;
            default: v = p * 4 + 40;
        endcase
        return (v > 63) ? 7'h3f : 7'(v);
    endfunction

    // One unit interval; mode 4 sends without checking
    task automatic pulse(input logic mark, input logic neg, input int mode, input int trim);
        logic [6:0] e;
        logic [6:0] seen;
        step(1);
        sv = 1'b1;
        sm = mark;
        sn = neg;
        step(1);
        sv = 1'b0;
        for (int p = 0; p < 16; p++) begin
            step(p == 0 ? 1 : 3);
            e = wave(mode, p, trim);
            seen = (dac[5:0] === 6'h00) ? 7'h00 : dac;
            if (mode < 4) check({1'b0, seen}, {1'b0, (e != 0) && neg, e[5:0]});
        end
    endtask

    task automatic flush();
        repeat (4) pulse(1'b0, 1'b0, 4, 0);
    endtask

    initial begin
        #500000;
        fail_count++;
        conclude();
    end

    initial begin
        {rst, wr, rd, hw, s_tri, s_term, mfail, pd, rloop, mpat, sv, sm, sn} = 13'h1000;
        {addr, wdata, s_shape, run} = 21'h1;
        s_term = 1'b1;
        step(4);
        check({6'h0, poe, noe}, 8'h00);
        step(4);
        rst = 1'b0;
        rreg(`OFF_TRIM);
        check(rv, 8'h21);
        rreg(`OFF_SHAPE);
        check(rv, 8'h00);
        rreg(8'h0b);
        check(rv, 8'h00);
        wreg(`OFF_STAT, 8'hff);
        rreg(`OFF_STAT);
        check(rv, 8'h00);
        oe(1'b1);
        // Termination through registers and straps
        wreg(`OFF_TERM, 8'h00);
        check({6'h0, tint, t120}, 8'h02);
        wreg(`OFF_TERM, 8'h01);
        check({6'h0, tint, t120}, 8'h03);
        wreg(`OFF_TERM, 8'h04);
        check({7'h0, tint}, 8'h00);
        hw = 1'b1;
        s_shape = 4'h1;
        s_term = 1'b0;
        step(6);
        check({7'h0, tint}, 8'h00);
        s_term = 1'b1;
        step(6);
        check({6'h0, tint, t120}, 8'h03);
        s_shape = 4'h0;
        step(6);
        check({6'h0, tint, t120}, 8'h02);
        s_tri = 1'b1;
        oe(1'b0);
        s_tri = 1'b0;
        oe(1'b1);
        hw = 1'b0;
        // Driver float causes
        wreg(`OFF_SHAPE, 8'h10);
        oe(1'b0);
        wreg(`OFF_SHAPE, 8'h00);
        oe(1'b1);
        pd = 1'b1;
        oe(1'b0);
        pd = 1'b0;
        oe(1'b1);
        mfail = 1'b1;
        oe(1'b0);
        mfail = 1'b0;
        oe(1'b1);
        wreg(`OFF_MASK, 8'h02);
        @(posedge tx_clock_in);
        run = 1'b0;
        step(50);
        check({6'h0, poe, noe}, 8'h03);
        step(50);
        check({5'h0, poe, noe, irq}, 8'h01);
        rloop = 1'b1;
        oe(1'b1);
        rreg(`OFF_STAT);
        check(rv, 8'h02);
        mpat = 1'b1;
        rloop = 1'b0;
        oe(1'b1);
        mpat = 1'b0;
        run = 1'b1;
        step(150);
        oe(1'b1);
        // Waveform store
        for (int u = 0; u < 4; u++) begin
            for (int s = 0; s < 16; s++) begin
                ram(u[1:0], s[3:0], 1'b0, tbl(u, s));
            end
        end
        ram(2'd0, 4'hf, 1'b1, 8'h00);
        check(rv, 8'h3c);
        ram(2'd1, 4'h3, 1'b1, 8'h00);
        check(rv, 8'h28);
        ram(2'd3, 4'hf, 1'b0, 8'h7f);
        ram(2'd3, 4'hf, 1'b1, 8'h00);
        check(rv, 8'h7f);
        ram(2'd3, 4'hf, 1'b0, 8'h00);
        // Preset templates
        wreg(`OFF_TERM, 8'h00);
        wreg(`OFF_SHAPE, 8'h00);
        pulse(1'b1, 1'b0, 0, 0);
        wreg(`OFF_TERM, 8'h01);
        wreg(`OFF_SHAPE, 8'h01);
        pulse(1'b1, 1'b1, 1, 0);
        wreg(`OFF_TERM, 8'h04);
        wreg(`OFF_TRIM, 8'h11);
        pulse(1'b1, 1'b0, 1, 0);
        // Arbitrary waveform with scaling
        wreg(`OFF_SHAPE, 8'h0c);
        flush();
        pulse(1'b1, 1'b0, 2, 17);
        wreg(`OFF_TRIM, 8'h21);
        wreg(`OFF_SHAPE, 8'h0f);
        flush();
        pulse(1'b1, 1'b0, 2, 33);
        // Overlap overflow
        rreg(`OFF_STAT);
        wreg(`OFF_MASK, 8'h00);
        flush();
        check({7'h0, irq}, 8'h00);
        pulse(1'b1, 1'b0, 4, 0);
        pulse(1'b1, 1'b0, 3, 0);
        check({7'h0, irq}, 8'h00);
        wreg(`OFF_MASK, 8'h01);
        check({7'h0, irq}, 8'h01);
        pulse(1'b0, 1'b0, 4, 0);
        rreg(`OFF_STAT);
        check(rv, 8'h01);
        rreg(`OFF_STAT);
        check(rv, 8'h00);
        check({7'h0, irq}, 8'h00);
        // Reset in mid-run
        wreg(`OFF_TRIM, 8'h05);
        rst = 1'b1;
        step(2);
        check({6'h0, poe, noe}, 8'h00);
        rst = 1'b0;
        rreg(`OFF_TRIM);
        check(rv, 8'h21);
        conclude();
    end
endmodule
`default_nettype wire
